/* hw/rx_irq_pkg.sv */
// package: register map, field positions and reset values of the receive flag block
package rx_irq_pkg;
  // byte addresses on the AXI4-Lite register bus
  localparam logic [7:0] STATUS_OFS     = 8'h00;
  localparam logic [7:0] ENABLE_OFS     = 8'h04;
  localparam logic [7:0] ERR_SRC_OFS    = 8'h08;
  localparam logic [7:0] EVT_STATUS_OFS = 8'h0c;
  localparam logic [7:0] EVT_MASK_OFS   = 8'h10;
  // receive status / enable bit positions
  localparam int RDY_BIT   = 7;
  localparam int START_BIT = 2;
  localparam int DONE_BIT  = 1;
  localparam int ERR_BIT   = 0;
  localparam logic [7:0] FLAG_MASK   = 8'h87;
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] ENABLE_RST  = 8'h00;
  // error source positions
  localparam int OVR_BIT = 3;
  localparam int TIM_BIT = 2;
  localparam int MAX_BIT = 1;
  localparam int PAR_BIT = 0;
  localparam logic [3:0] ERR_SRC_RST = 4'h0;
  // event status / mask: one bit per receive interrupt request
  localparam logic [3:0] EVT_RST  = 4'h0;
  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* hw/rx_irq_ctrl.sv */
// receive completion flags, enables and interrupt gating with an AXI4-Lite slave
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module rx_irq_ctrl (
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        CE_I,
  // receive engine events, one-cycle pulses
  input  wire logic        RX_START_I,
  input  wire logic        RX_DONE_I,
  input  wire logic        RX_SHORT_END_I,
  input  wire logic        RX_DATA_READY_I,
  input  wire logic        RX_DATA_TAKEN_I,
  input  wire logic        RX_NEW_FRAME_I,
  input  wire logic [3:0]  RX_ERR_I,
  // AXI4-Lite slave
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // outputs
  output logic [3:0]       RX_IRQ_REQ_O,
  output logic             ABORT_TO_WAIT_O,
  output logic             IRQ_O
);
  import rx_irq_pkg::*;

  logic [7:0]  receive_status_reg;
  logic [7:0]  receive_irq_enable;
  logic [3:0]  receive_error_source_reg;
  logic [7:0]  read_armed;
  logic [3:0]  evt_status;
  logic [3:0]  evt_mask;
  logic        start_seen;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        rd_fire;
  logic        lane0;
  logic [7:0]  wbyte;
  logic [7:0]  next_status;
  logic [7:0]  status_clr;
  logic [7:0]  status_set;
  logic [3:0]  next_req;
  logic        err_any;
  logic        err_live;
  logic [3:0]  evt_prev;

  //****************************************
  // AXI4-Lite write path
  //****************************************
  assign wr_fire = aw_held && w_held && !BVALID_O;
  assign lane0   = w_strb[0];
  assign wbyte   = w_data[7:0];

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      AWREADY_O <= 1'b0;
      WREADY_O  <= 1'b0;
      BVALID_O  <= 1'b0;
      BRESP_O   <= RESP_OK;
    end else if (CE_I) begin
      AWREADY_O <= !aw_held && !AWREADY_O && AWVALID_I;
      WREADY_O  <= !w_held && !WREADY_O && WVALID_I;
      if (AWVALID_I && AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_held <= 1'b1;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end
      if (wr_fire) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        BVALID_O <= 1'b1;
        case (aw_addr)
          STATUS_OFS, ENABLE_OFS, ERR_SRC_OFS, EVT_STATUS_OFS, EVT_MASK_OFS: BRESP_O <= RESP_OK;
          default: BRESP_O <= RESP_SLVERR;
        endcase
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  //****************************************
  // AXI4-Lite read path
  //****************************************
  assign rd_fire = ARVALID_I && ARREADY_O;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h0000_0000;
      RRESP_O   <= RESP_OK;
    end else if (CE_I) begin
      ARREADY_O <= !ARREADY_O && !RVALID_O && ARVALID_I;
      if (rd_fire) begin
        RVALID_O <= 1'b1;
        RRESP_O  <= RESP_OK;
        case (ARADDR_I)
          STATUS_OFS:     RDATA_O <= {24'h000000, receive_status_reg};
          ENABLE_OFS:     RDATA_O <= {24'h000000, receive_irq_enable};
          ERR_SRC_OFS:    RDATA_O <= {28'h0000000, receive_error_source_reg};
          EVT_STATUS_OFS: RDATA_O <= {28'h0000000, evt_status};
          EVT_MASK_OFS:   RDATA_O <= {28'h0000000, evt_mask};
          default: begin
            RDATA_O <= 32'h0000_0000;
            RRESP_O <= RESP_SLVERR;
          end
        endcase
      end else if (RVALID_O && RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end

  //****************************************
  // read-then-write-0 arming
  //****************************************
  // a flag read as 1 arms its clear; only the next status write uses the arm, clearing it if that write holds 0
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      read_armed <= 8'h00;
    end else if (CE_I) begin
      if (rd_fire && ARADDR_I == STATUS_OFS) begin
        read_armed <= receive_status_reg & FLAG_MASK;
      end else if (wr_fire && aw_addr == STATUS_OFS && lane0) begin
        read_armed <= 8'h00;
      end
    end
  end

  //****************************************
  // receive status flags
  //****************************************
  assign err_any  = |RX_ERR_I;
  // error sources count only once a start has been seen for this frame
  assign err_live = err_any && start_seen;

  always_comb begin
    status_set             = 8'h00;
    status_set[START_BIT]  = RX_START_I;
    status_set[DONE_BIT]   = RX_DONE_I && !err_any;
    status_set[ERR_BIT]    = (RX_SHORT_END_I && start_seen) || err_live;
    status_set[RDY_BIT]    = RX_DATA_READY_I;
    status_clr = 8'h00;
    if (wr_fire && aw_addr == STATUS_OFS && lane0) begin
      status_clr = read_armed & ~wbyte & FLAG_MASK;
    end
    if (RX_DATA_TAKEN_I) begin
      status_clr[RDY_BIT] = 1'b1;
    end
    // set wins over a clear in the same cycle
    next_status = ((receive_status_reg & ~status_clr) | status_set) & FLAG_MASK;
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      receive_status_reg <= STATUS_RST;
    end else if (CE_I) begin
      receive_status_reg <= next_status;
    end
  end

  // tracks the start of the current frame, independent of the start flag clear
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      start_seen      <= 1'b0;
      ABORT_TO_WAIT_O <= 1'b0;
    end else if (CE_I) begin
      ABORT_TO_WAIT_O <= err_any && !start_seen && !RX_START_I;
      if (RX_START_I) begin
        start_seen <= 1'b1;
      end else if (RX_NEW_FRAME_I || RX_DONE_I || RX_SHORT_END_I || err_any) begin
        start_seen <= 1'b0;
      end
    end
  end

  //****************************************
  // error source register
  //****************************************
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      receive_error_source_reg <= ERR_SRC_RST;
    end else if (CE_I) begin
      if (err_live) begin
        receive_error_source_reg <= receive_error_source_reg | RX_ERR_I;
      end else if (wr_fire && aw_addr == ERR_SRC_OFS && lane0) begin
        receive_error_source_reg <= receive_error_source_reg & wbyte[3:0];
      end
    end
  end

  //****************************************
  // enable register
  //****************************************
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      receive_irq_enable <= ENABLE_RST;
    end else if (CE_I && wr_fire && aw_addr == ENABLE_OFS && lane0) begin
      receive_irq_enable <= wbyte & FLAG_MASK;
    end
  end

  //****************************************
  // interrupt requests and summary
  //****************************************
  always_comb begin
    next_req[3] = receive_status_reg[RDY_BIT] && receive_irq_enable[RDY_BIT];
    next_req[2] = receive_status_reg[START_BIT] && receive_irq_enable[START_BIT];
    next_req[1] = receive_status_reg[DONE_BIT] && receive_irq_enable[DONE_BIT];
    next_req[0] = receive_status_reg[ERR_BIT] && receive_irq_enable[ERR_BIT];
  end

  // event status latches each request's rising edge; write 1 clears, set wins
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      RX_IRQ_REQ_O <= 4'h0;
      evt_prev     <= 4'h0;
      evt_status   <= EVT_RST;
      evt_mask     <= EVT_RST;
      IRQ_O        <= 1'b0;
    end else if (CE_I) begin
      RX_IRQ_REQ_O <= next_req;
      evt_prev     <= next_req;
      if (wr_fire && aw_addr == EVT_MASK_OFS && lane0) begin
        evt_mask <= wbyte[3:0];
      end
      if (wr_fire && aw_addr == EVT_STATUS_OFS && lane0) begin
        evt_status <= (evt_status & ~wbyte[3:0]) | (next_req & ~evt_prev);
      end else begin
        evt_status <= evt_status | (next_req & ~evt_prev);
      end
      IRQ_O <= |(evt_status & evt_mask);
    end
  end
endmodule

/* bench/rx_irq_ctrl_monitor.sv */
// checker: early-error abort, reset state and register-bus answer timing
`timescale 1ns/1ps
module rx_irq_ctrl_monitor (
  input wire logic       CLK_I,
  input wire logic       SRST_I,
  input wire logic       CE_I,
  input wire logic       RX_START_I,
  input wire logic       RX_DONE_I,
  input wire logic       RX_SHORT_END_I,
  input wire logic       RX_NEW_FRAME_I,
  input wire logic [3:0] RX_ERR_I,
  input wire logic       ARVALID_I,
  input wire logic       ARREADY_O,
  input wire logic       AWREADY_O,
  input wire logic       BVALID_O,
  input wire logic       BREADY_I,
  input wire logic       RVALID_O,
  input wire logic       RREADY_I,
  input wire logic [3:0] RX_IRQ_REQ_O,
  input wire logic       ABORT_TO_WAIT_O,
  input wire logic       IRQ_O
);
  logic seen;
  logic ends;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I || !CE_I);
  // ***************
  // start tracking
  // ***************
  assign ends = RX_DONE_I || RX_SHORT_END_I || RX_NEW_FRAME_I || RX_ERR_I != 4'h0;
  always_ff @(posedge CLK_I) begin
    if (SRST_I) seen <= 1'b0;
    else if (CE_I && ends) seen <= 1'b0;
    else if (CE_I && RX_START_I) seen <= 1'b1;
  end
  a_abort_on_err: assert property (RX_ERR_I != 4'h0 && !seen |=> ABORT_TO_WAIT_O)
    else $error("no abort after early error");
  a_abort_cause: assert property (ABORT_TO_WAIT_O |-> $past(RX_ERR_I) != 4'h0 && !$past(seen))
    else $error("abort without early error");
  a_no_err_flag: assert property (RX_ERR_I != 4'h0 && !seen && !RX_IRQ_REQ_O[0]
    |-> ##2 !RX_IRQ_REQ_O[0]) else $error("error-end raised before start");
  a_reset_quiet: assert property (disable iff (1'b0) SRST_I && CE_I |=> RX_IRQ_REQ_O == 4'h0
    && !IRQ_O && !ABORT_TO_WAIT_O && !BVALID_O && !RVALID_O) else $error("outputs after reset");
  a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read answer late");
  a_rvalid_drop: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read answer held");
  a_bvalid_drop: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
    else $error("write answer held");
  a_awready_pulse: assert property (AWREADY_O |=> !AWREADY_O)
    else $error("awready not a pulse");
endmodule
bind rx_irq_ctrl rx_irq_ctrl_monitor u_mon (.*);

/* bench/rx_engine_model.sv */
// receive engine model: one-cycle event pulses toward the flag block
`timescale 1ns/1ps
module rx_engine_model (
  input  wire logic       clk_i,
  output logic            start_o,
  output logic            done_o,
  output logic            short_o,
  output logic            ready_o,
  output logic            taken_o,
  output logic            new_frame_o,
  output logic [3:0]      err_o
);
  logic [9:0] ev_v;
  initial ev_v <= 10'h000;
  assign {start_o, done_o, short_o, ready_o, taken_o, new_frame_o, err_o} = ev_v;
  // spaced three cycles so flag and request stages settle before the next event
  task automatic ev(logic [9:0] v);
    ev_v <= v;
    @(posedge clk_i);
    ev_v <= 10'h000;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

/* bench/rx_irq_ctrl_tb_top.sv */
// testbench: receive flag block over AXI4-Lite with an engine model
`timescale 1ns/1ps
module rx_irq_ctrl_tb_top;
  import rx_irq_pkg::*;
  logic CLK_I, SRST_I, CE_I, AWVALID_I, WVALID_I;
  logic BREADY_I, ARVALID_I, RREADY_I;
  logic [7:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O;
  logic [3:0] WSTRB_I, RX_IRQ_REQ_O, RX_ERR_I;
  logic [1:0] BRESP_O, RRESP_O;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, ABORT_TO_WAIT_O, IRQ_O;
  logic RX_START_I, RX_DONE_I, RX_SHORT_END_I, RX_DATA_READY_I, RX_DATA_TAKEN_I;
  logic RX_NEW_FRAME_I;
  integer seed = 32'hba29d65c;
  int n_fail = 0;
  int n_tests = 0;
  rx_irq_ctrl dut (.*);
  rx_engine_model eng (.clk_i(CLK_I), .start_o(RX_START_I), .done_o(RX_DONE_I),
    .short_o(RX_SHORT_END_I), .ready_o(RX_DATA_READY_I), .taken_o(RX_DATA_TAKEN_I),
    .new_frame_o(RX_NEW_FRAME_I), .err_o(RX_ERR_I));
  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end
  // ***************
  // shared tasks
  // ***************
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] e, logic [3:0] s = 4'h1);
    int i;
    AWADDR_I <= a;
    WDATA_I <= d;
    WSTRB_I <= s;
    {AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
    for (i = 0; i < 40 && !BVALID_O; i++) begin
      @(posedge CLK_I);
      if (AWREADY_O) AWVALID_I <= 1'b0;
      if (WREADY_O) WVALID_I <= 1'b0;
    end
    BREADY_I <= 1'b0;
    chk("bresp", e, BRESP_O);
    if (i == 40) begin
      n_fail++;
      complete_run();
    end
    @(posedge CLK_I);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    int i;
    ARADDR_I <= a;
    {ARVALID_I, RREADY_I} <= 2'h3;
    for (i = 0; i < 40 && !RVALID_O; i++) begin
      @(posedge CLK_I);
      if (ARREADY_O) ARVALID_I <= 1'b0;
    end
    RREADY_I <= 1'b0;
    chk("rresp", a > EVT_MASK_OFS ? RESP_SLVERR : RESP_OK, RRESP_O);
    chk("rdata", e, RDATA_O);
    if (i == 40) begin
      n_fail++;
      complete_run();
    end
    @(posedge CLK_I);
  endtask
  initial begin
    repeat (100000) @(posedge CLK_I);
    n_fail++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    int k;
    {SRST_I, CE_I} <= 2'b11;
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} <= 5'h00;
    {AWADDR_I, ARADDR_I, WDATA_I, WSTRB_I} <= 52'h0;
    repeat (16) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    for (k = 0; k < 20; k += 4) rdc(8'(k), 32'h0);
    chk("req", 4'h0, RX_IRQ_REQ_O);
    for (k = 0; k < 6; k++) begin
      d = k ? $random(seed) : 32'hff;
      axw(ENABLE_OFS, d, RESP_OK);
      rdc(ENABLE_OFS, d & 32'h87);
    end
    // byte lane 0 not strobed: the write must leave the enables alone
    axw(ENABLE_OFS, ~d, RESP_OK, 4'he);
    rdc(ENABLE_OFS, d & 32'h87);
    axw(8'h14, 32'h1, RESP_SLVERR);
    rdc(8'h14, 32'h0);
    $display("test registers done");
    axw(ENABLE_OFS, 32'h87, RESP_OK);
    axw(EVT_MASK_OFS, 32'hf, RESP_OK);
    eng.ev(10'h200);
    eng.ev(10'h100);
    chk("req", 4'h6, RX_IRQ_REQ_O);
    rdc(STATUS_OFS, 32'h06);
    chk("irq", 1'b1, IRQ_O);
    rdc(EVT_STATUS_OFS, 32'h6);
    axw(STATUS_OFS, 32'hff, RESP_OK);
    axw(STATUS_OFS, 32'h00, RESP_OK);
    rdc(STATUS_OFS, 32'h06);
    axw(STATUS_OFS, 32'h04, RESP_OK);
    rdc(STATUS_OFS, 32'h04);
    $display("test normal frame done");
    for (k = 0; k < 4; k++) begin
      eng.ev(10'h010);
      eng.ev(10'h200);
      eng.ev(10'(1 << k));
      rdc(STATUS_OFS, 32'h05);
      axw(STATUS_OFS, 32'h04, RESP_OK);
      rdc(STATUS_OFS, 32'h04);
      rdc(ERR_SRC_OFS, 32'(1 << k));
      axw(ERR_SRC_OFS, 32'h0, RESP_OK);
    end
    eng.ev(10'h010);
    eng.ev(10'h008);
    rdc(STATUS_OFS, 32'h04);
    rdc(ERR_SRC_OFS, 32'h0);
    eng.ev(10'h200);
    eng.ev(10'h080);
    rdc(STATUS_OFS, 32'h05);
    axw(STATUS_OFS, 32'h0, RESP_OK);
    eng.ev(10'h010);
    eng.ev(10'h200);
    eng.ev(10'h104);
    rdc(STATUS_OFS, 32'h05);
    $display("test error frames done");
    eng.ev(10'h040);
    chk("req", 4'hd, RX_IRQ_REQ_O);
    eng.ev(10'h020);
    rdc(STATUS_OFS, 32'h05);
    axw(ENABLE_OFS, 32'h0, RESP_OK);
    axw(EVT_STATUS_OFS, 32'hf, RESP_OK);
    chk("irq", 1'b0, IRQ_O);
    rdc(EVT_STATUS_OFS, 32'h0);
    axw(EVT_MASK_OFS, 32'h0, RESP_OK);
    repeat (3) @(posedge CLK_I);
    chk("req", 4'h0, RX_IRQ_REQ_O);
    chk("irq", 1'b0, IRQ_O);
    $display("test gating done");
    // clock enable low: a data-ready pulse must not reach the flags
    CE_I <= 1'b0;
    eng.ev(10'h040);
    CE_I <= 1'b1;
    rdc(STATUS_OFS, 32'h05);
    $display("test clock enable done");
    complete_run();
  end
endmodule
